// *** rim_pkg.sv ***
// Package: constants for the remote I/O signal mapper
package rim_pkg;

	// ****************************************
	// Sizes
	// ****************************************
	localparam int SLOTS = 16;
	localparam int SEL_W = 8;
	localparam int FUNC_N = 256;
	localparam int DIRECT_N = 6;

	// ****************************************
	// Function codes
	// ****************************************
	localparam logic [7:0] CODE_NONE = 8'h00;
	localparam logic [7:0] CODE_INTERLOCK = 8'h10;

	// ****************************************
	// Register map (word addresses)
	// ****************************************
	localparam logic [5:0] ADDR_IN_SEL = 6'h00;
	localparam logic [5:0] ADDR_OUT_SEL = 6'h10;
	localparam logic [5:0] ADDR_RIN = 6'h20;
	localparam logic [5:0] ADDR_ROUT = 6'h21;
	localparam logic [5:0] ADDR_ILK = 6'h22;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [7:0] IN_SEL_RST = 8'h00;
	localparam logic [7:0] OUT_SEL_RST [16] = '{
		8'h40, 8'h41, 8'h42, 8'h20,
		8'h90, 8'h84, 8'h87, 8'h81,
		8'h88, 8'hA0, 8'hA1, 8'hA2,
		8'h9B, 8'h86, 8'h8A, 8'h8C
	};

endpackage

// *** rim_mapper.sv ***
// Design: remote I/O signal mapper crossbar
`timescale 1ns/1ps
module rim_mapper (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Register port
	input wire logic [5:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [15:0] rdata,
	// Network remote I/O words
	input wire logic [15:0] net_rin,
	output logic [15:0] net_rout,
	// Direct terminals, already mapped per function
	input wire logic [255:0] direct_func,
	input wire logic direct_ilk_mapped,
	input wire logic [5:0] direct_pins,
	// Internal functions and status
	output logic [255:0] func_active,
	output logic operator_interlock_in,
	input wire logic [255:0] status_vec
);

	// ****************************************
	// Selector registers
	// ****************************************
	logic [7:0] in_sel_reg [16];
	logic [7:0] out_sel_reg [16];
	logic [15:0] rin_meta_reg;
	logic [15:0] rin_reg;
	logic [255:0] func_reg;
	logic ilk_reg;
	logic [15:0] rout_reg;

	always_ff @(posedge clk) begin
		for (int i = 0; i < 16; i++) begin
			if (!rstn) begin
				in_sel_reg[i] <= rim_pkg::IN_SEL_RST;
				out_sel_reg[i] <= rim_pkg::OUT_SEL_RST[i];
			end else if (wr && addr == (rim_pkg::ADDR_IN_SEL | 6'(i))) begin
				in_sel_reg[i] <= wdata;
			end else if (wr && addr == (rim_pkg::ADDR_OUT_SEL | 6'(i))) begin
				out_sel_reg[i] <= wdata;
			end
		end
	end

	// ****************************************
	// Network input synchroniser
	// ****************************************
	always_ff @(posedge clk) begin
		if (!rstn) begin
			rin_meta_reg <= 16'h0000;
			rin_reg <= 16'h0000;
		end else begin
			rin_meta_reg <= net_rin;
			rin_reg <= rin_meta_reg;
		end
	end

	// ****************************************
	// Input crossbar
	// ****************************************
	function automatic logic [255:0] decode(input logic [7:0] code);
		logic [255:0] v;
		v = '0;
		if (code != rim_pkg::CODE_NONE) begin
			v[code] = 1'b1;
		end
		return v;
	endfunction

	logic [255:0] remote_func;
	logic remote_ilk_mapped;
	logic [255:0] func_next;
	logic ilk_next;

	always_comb begin
		remote_func = '0;
		remote_ilk_mapped = 1'b0;
		for (int i = 0; i < 16; i++) begin
			if (rin_reg[i]) begin
				remote_func = remote_func | decode(in_sel_reg[i]);
			end
			if (in_sel_reg[i] == rim_pkg::CODE_INTERLOCK) begin
				remote_ilk_mapped = 1'b1;
			end
		end
		func_next = remote_func | direct_func;
		if (!remote_ilk_mapped && !direct_ilk_mapped) begin
			ilk_next = 1'b1;
		end else if (remote_ilk_mapped && direct_ilk_mapped) begin
			ilk_next = remote_func[rim_pkg::CODE_INTERLOCK]
				& direct_func[rim_pkg::CODE_INTERLOCK];
		end else begin
			ilk_next = func_next[rim_pkg::CODE_INTERLOCK];
		end
		func_next[rim_pkg::CODE_INTERLOCK] = ilk_next;
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			func_reg <= '0;
			ilk_reg <= 1'b1;
		end else begin
			func_reg <= func_next;
			ilk_reg <= ilk_next;
		end
	end

	assign func_active = func_reg;
	assign operator_interlock_in = ilk_reg;

	// ****************************************
	// Output crossbar
	// ****************************************
	always_ff @(posedge clk) begin
		for (int i = 0; i < 16; i++) begin
			if (!rstn) begin
				rout_reg[i] <= 1'b0;
			end else if (out_sel_reg[i] == rim_pkg::CODE_NONE) begin
				rout_reg[i] <= 1'b0;
			end else begin
				rout_reg[i] <= status_vec[out_sel_reg[i]];
			end
		end
	end

	assign net_rout = rout_reg;

	// ****************************************
	// Read back
	// ****************************************
	always_ff @(posedge clk) begin
		if (!rstn) begin
			rdata <= 16'h0000;
		end else if (rd) begin
			if (addr[5:4] == 2'b00) begin
				rdata <= {8'h00, in_sel_reg[addr[3:0]]};
			end else if (addr[5:4] == 2'b01) begin
				rdata <= {8'h00, out_sel_reg[addr[3:0]]};
			end else if (addr == rim_pkg::ADDR_RIN) begin
				rdata <= rin_reg;
			end else if (addr == rim_pkg::ADDR_ROUT) begin
				rdata <= rout_reg;
			end else if (addr == rim_pkg::ADDR_ILK) begin
				rdata <= {15'h0000, ilk_reg};
			end else begin
				rdata <= 16'h0000;
			end
		end else begin
			rdata <= 16'h0000;
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	// Status bit routed to slot 2, for the routing check
	logic out2_pick;
	assign out2_pick = status_vec[out_sel_reg[2]];

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	reset_sel_a: assert property ($rose(rstn) |->
		out_sel_reg[0] == 8'h40 && in_sel_reg[0] == 8'h00)
		else $error("selector reset values wrong");
	ilk_unmapped_a: assert property (!remote_ilk_mapped
		&& !direct_ilk_mapped |=> operator_interlock_in)
		else $error("unmapped interlock not active");
	ilk_and_a: assert property (remote_ilk_mapped && direct_ilk_mapped
		&& !direct_func[8'h10] |=> !operator_interlock_in)
		else $error("interlock not AND of both paths");
	or_merge_a: assert property (direct_func[1] |=> func_active[1])
		else $error("direct source not ORed in");
	slot_route_a: assert property (rin_reg[0]
		&& in_sel_reg[0] == 8'h05 |=> func_active[5])
		else $error("input slot not routed");
	none_out_a: assert property (out_sel_reg[3] == 8'h00
		|=> net_rout[3] == 1'b0)
		else $error("empty output slot not low");
	out_route_a: assert property (out_sel_reg[2] != 8'h00
		|=> net_rout[2] == $past(out2_pick))
		else $error("output slot not routed");
	sync_path_a: assert property (net_rin[4] ##1 net_rin[4]
		|=> rin_reg[4])
		else $error("remote input not synchronised");
	wr_sel_a: assert property (wr && addr == 6'h03
		|=> in_sel_reg[3] == $past(wdata))
		else $error("selector write lost");
	reset_tail_a: assert property ($rose(rstn) |->
		out_sel_reg[15] == 8'h8C && out_sel_reg[4] == 8'h90)
		else $error("output selector defaults wrong");
	ilk_read_a: assert property (rd && addr == rim_pkg::ADDR_ILK
		|=> rdata == {15'h0000, $past(ilk_reg)})
		else $error("interlock read back wrong");
	rin_read_a: assert property (rd && addr == rim_pkg::ADDR_RIN
		|=> rdata == $past(rin_reg))
		else $error("remote input read back wrong");
	rd_idle_a: assert property (!rd |=> rdata == 16'h0000)
		else $error("read data not cleared");

	ilk_both_c: cover property (remote_ilk_mapped && direct_ilk_mapped);
	multi_src_c: cover property (rin_reg[0] && rin_reg[1]
		&& in_sel_reg[0] == in_sel_reg[1] && in_sel_reg[0] != 8'h00);
	out_write_c: cover property (wr && addr[5:4] == 2'b01);
	none_out_c: cover property (out_sel_reg[3] == 8'h00);
	reset_rel_c: cover property ($rose(rstn));

endmodule // rim_mapper

// *** rim_net_model.sv ***
// Partner: network controller exchanging remote I/O words
`timescale 1ns/1ps
module rim_net_model (
	// Clock
	input wire logic clk,
	// Bench side
	input wire logic [15:0] send,
	output logic [15:0] seen,
	// Link side
	input wire logic [15:0] net_rout,
	output logic [15:0] net_rin
);
	// Words leave and arrive once per cycle
	always @(posedge clk) begin
		net_rin <= send;
		seen <= net_rout;
	end
endmodule // rim_net_model

// *** rim_mapper_tb_top.sv ***
// Testbench: remote I/O mapper against a bench model
`timescale 1ns/1ps
module rim_mapper_tb_top;
	logic clk = 0, rstn = 0, wr = 0, rd = 0, ilk_map = 0, ilk;
	logic [5:0] addr = 6'h00;
	logic [7:0] wdata = 8'h00;
	logic [15:0] rdata, net_rin, net_rout, seen, send = 16'h0000;
	logic [255:0] direct_func = '0, status_vec = '0, func_active;
	logic [7:0] dflt [16] = '{8'h40, 8'h41, 8'h42, 8'h20, 8'h90, 8'h84,
		8'h87, 8'h81, 8'h88, 8'hA0, 8'hA1, 8'hA2, 8'h9B, 8'h86, 8'h8A, 8'h8C};
	int fails = 0, checked = 0, seed = 41817, isel[16], osel[16];
	always #10 clk = ~clk;
	rim_mapper uut (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .net_rin(net_rin),
		.net_rout(net_rout), .direct_func(direct_func),
		.direct_ilk_mapped(ilk_map), .direct_pins(6'h00),
		.func_active(func_active), .operator_interlock_in(ilk),
		.status_vec(status_vec));
	rim_net_model net (.clk(clk), .send(send), .seen(seen),
		.net_rout(net_rout), .net_rin(net_rin));
	task automatic chk(input logic [255:0] got, input logic [255:0] exp);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wreg(input int a, input int d);
		@(posedge clk);
		addr <= 6'(a);
		wdata <= 8'(d);
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rreg(input int a, input logic [15:0] e);
		@(posedge clk);
		addr <= 6'(a);
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		chk(rdata, e);
	endtask
	task automatic readall();
		for (int i = 0; i < 32; i++)
			rreg(i, 16'(i < 16 ? isel[i % 16] : osel[i % 16]));
	endtask
	task automatic verify();
		logic [255:0] ef;
		logic [255:0] g;
		logic [15:0] eo;
		logic rem;
		logic hit;
		logic ei;
		repeat (6) @(posedge clk);
		@(negedge clk);
		ef = direct_func;
		rem = 1'b0;
		hit = 1'b0;
		for (int i = 0; i < 16; i++) begin
			if (send[i] && isel[i] != 0)
				ef[isel[i]] = 1'b1;
			if (isel[i] == 16) begin
				hit = 1'b1;
				rem = rem | send[i];
			end
			eo[i] = osel[i] == 0 ? 1'b0 : status_vec[osel[i]];
		end
		g = func_active;
		g[16] = 1'b0;
		ef[16] = 1'b0;
		chk(g, ef);
		if (!ilk_map) begin
			ei = hit ? rem : 1'b1;
			chk(ilk, ei);
		end else begin
			ei = hit ? rem & direct_func[16] : direct_func[16];
			chk(ilk, ei);
		end
		chk(seen, eo);
		rreg(32, send);
		rreg(33, eo);
		rreg(34, {15'h0000, ei});
	endtask
	task automatic give_verdict();
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		foreach (isel[i]) begin
			isel[i] = 0;
			osel[i] = dflt[i];
		end
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		readall();
		verify();
		for (int r = 0; r < 12; r++) begin
			@(posedge clk);
			for (int k = 0; k < 8; k++)
				status_vec[k * 32 +: 32] <= $random(seed);
			// Direct interlock only active when mapped on a terminal
			direct_func[31:0] <= $random(seed) & $random(seed)
				& {15'h7FFF, r[1], 16'hFFFF};
			ilk_map <= r[1];
			send <= 16'($random(seed)) | 16'(r == 0);
			for (int i = 0; i < 16; i++) begin
				isel[i] = (r == 0 && i == 0) ? 5 : $random(seed) & 8'h1F;
				wreg(i, isel[i]);
			end
			for (int i = 0; i < 16; i++) begin
				osel[i] = (i == r) ? 0 : $random(seed) & 8'hFF;
				wreg(16 + i, osel[i]);
			end
			verify();
			readall();
		end
		rreg(48, 16'h0000);
		wreg(63, 255);
		readall();
		// Second reset in mid-run brings back the defaults
		@(posedge clk);
		rstn <= 1'b0;
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		foreach (isel[i]) begin
			isel[i] = 0;
			osel[i] = dflt[i];
		end
		readall();
		verify();
		give_verdict();
	end
endmodule // rim_mapper_tb_top
